// >>> rtl/smws_params.svh
// Named constants of the static memory wait-state controller.
// Assumes inclusion by the package, the controller, the property module and the bench.
`ifndef SMWS_PARAMS_SVH
`define SMWS_PARAMS_SVH

// ****************************************
// Sizes and encodings
// ****************************************
`define SMWS_NUM_CS            4
`define SMWS_CS_W              2
`define SMWS_WAIT_OFF          2'h0
`define SMWS_WAIT_FROZEN       2'h2
`define SMWS_WAIT_READY        2'h3
`define SMWS_WAIT_RELEASED     1'b1
`define SMWS_STROBE_OFF        1'b1
`define SMWS_CS_OFF            4'hf
`define SMWS_CNT_ZERO          10'h000
`define SMWS_ONE10             10'h001
`define SMWS_FLT_ZERO          4'h0
`define SMWS_FLT_ONE           4'h1

// ****************************************
// Fixed slow clock waveforms
// ****************************************
`define SMWS_SLOW_RD_STB_SETUP 8'h01
`define SMWS_SLOW_RD_STB_PULSE 8'h01
`define SMWS_SLOW_RD_CS_SETUP  8'h00
`define SMWS_SLOW_RD_CS_PULSE  8'h02
`define SMWS_SLOW_RD_CYCLE     9'h002
`define SMWS_SLOW_WR_STB_SETUP 8'h01
`define SMWS_SLOW_WR_STB_PULSE 8'h01
`define SMWS_SLOW_WR_CS_SETUP  8'h00
`define SMWS_SLOW_WR_CS_PULSE  8'h03
`define SMWS_SLOW_WR_CYCLE     9'h003

`endif

// >>> rtl/smws_pkg.sv
// Types shared by the wait-state controller and its users.
// Assumes smws_params.svh is on the include path.
package smws_pkg;
`include "smws_params.svh"

   // ****************************************
   // Types
   // ****************************************

   typedef enum logic [1:0] {
      SMWS_IDLE,
      SMWS_RELOAD,
      SMWS_GATE,
      SMWS_ACCESS
   } smws_state_e;

   // Timing fields of one chip select, lengths already in cycles
   typedef struct packed {
      logic [7:0] read_strobe_setup_len;
      logic [7:0] read_strobe_pulse_len;
      logic [7:0] cs_read_setup_len;
      logic [7:0] cs_read_pulse_len;
      logic [8:0] read_cycle_len;
      logic [7:0] write_strobe_setup_len;
      logic [7:0] write_strobe_pulse_len;
      logic [7:0] cs_write_setup_len;
      logic [7:0] cs_write_pulse_len;
      logic [8:0] write_cycle_len;
      logic       read_mode;
      logic       write_mode;
      logic [3:0] float_cycles;
      logic       float_opt;
      logic [1:0] ext_wait_mode;
   } smws_cfg_s;

   // Waveform applied to the access in progress
   typedef struct packed {
      logic [7:0] stb_setup;
      logic [7:0] stb_pulse;
      logic [7:0] cs_setup;
      logic [7:0] cs_pulse;
      logic [8:0] cycle;
      logic [7:0] ctl_setup;
      logic [7:0] ctl_pulse;
   } smws_tim_s;

   typedef struct packed {
      logic                     is_write;
      logic [`SMWS_CS_W-1:0]    cs;
      smws_cfg_s                cfg;
   } smws_req_s;

   typedef struct packed {
      smws_state_e              state;
      logic [9:0]               cnt;
      smws_tim_s                tim;
      logic                     is_write;
      logic [`SMWS_CS_W-1:0]    cs;
      logic [1:0]               wait_mode;
      logic                     slow_cur;
      logic [3:0]               float_len;
      logic                     float_opt;
      logic [3:0]               flt_cnt;
      logic                     flt_pend;
      logic                     flt_opt;
      logic [`SMWS_CS_W-1:0]    flt_cs;
      logic                     slow_used;
      logic                     wait_s1;
      logic                     wait_s2;
      logic                     hold;
      logic                     rd_n;
      logic                     wr_n;
      logic [`SMWS_NUM_CS-1:0]  cs_n;
      logic                     ready;
      logic                     done;
   } smws_st_s;

endpackage : smws_pkg

// >>> rtl/smws_ctrl.sv
// Wait-state and timing engine of a static memory controller.
// Assumes a requester that presents one access at a time together with
// the timing fields of its chip select, and a memory that may answer
// with an active-low wait line from outside the clock domain.
//
// Contract
// - Optimised float overlaps next access setup
// - Unoptimised float ends before next access
// - Float counted from strobe rise, hold overlaps
// - Float applies to read then other access
// - Wait mode 10 frozen, 11 ready
// - Wait mode 00 ignores wait input
// - Wait sampled only in controlling pulse
// - Frozen wait halts access counter and outputs
// - Frozen release resumes where halted
// - Ready mode suspends in last pulse cycle
// - Ready wait outside last cycle ignored
// - Wait passes two-stage resynchroniser
// - Slow clock forces fixed waveforms
// - Slow read: 1/1 strobe, 0/2 cs, 2
// - Slow write: 1/1 strobe, 0/3 cs, 3
// - Access finishes with timing it started
// - Float length 0 to 15 cycles
// - Float starts at controlling strobe rise
// - Slow mode change inserts reload wait
`timescale 1ns/1ps
`include "smws_params.svh"
module smws_ctrl (
   input  wire logic                     clk_in,
   input  wire logic                     rst_n_in,
   input  wire logic                     req_valid_in,
   input  wire smws_pkg::smws_req_s      req_in,
   input  wire logic                     slow_clock_in,
   input  wire logic                     ext_wait_n_in,
   output logic                          req_ready_out,
   output logic                          done_out,
   output logic                          wait_hold_out,
   output logic                          read_strobe_n_out,
   output logic                          write_strobe_n_out,
   output logic [`SMWS_NUM_CS-1:0]       chip_select_n_out
);
   import smws_pkg::*;

   smws_st_s st_reg;
   smws_st_s st_next;
   logic     wait_on;
   logic     hold;
   logic     in_ctl;
   logic     last_ctl;

   // ****************************************
   // Helper functions
   // ****************************************

   // True while a counter value lies inside a setup/pulse window
   function automatic logic phase(input logic [9:0] c,
                                  input logic [7:0] s,
                                  input logic [7:0] p);
      logic [9:0] lo;
      logic [9:0] hi;
      lo = {2'h0, s};
      hi = {2'h0, s} + {2'h0, p};
      return (c >= lo) && (c < hi);
   endfunction : phase

   // Counter value of the last pulse cycle of the controlling strobe
   function automatic logic [9:0] ctl_last(input smws_tim_s t);
      return {2'h0, t.ctl_setup} + {2'h0, t.ctl_pulse} - `SMWS_ONE10;
   endfunction : ctl_last

   // Waveform of an access: fixed in slow clock mode, else programmed
   function automatic smws_tim_s timing(input smws_cfg_s c,
                                        input logic w,
                                        input logic slow);
      smws_tim_s t;
      logic      by_stb;
      t = '0;
      by_stb = w ? c.write_mode : c.read_mode;
      if (slow && !w) begin
         t.stb_setup = `SMWS_SLOW_RD_STB_SETUP;
         t.stb_pulse = `SMWS_SLOW_RD_STB_PULSE;
         t.cs_setup  = `SMWS_SLOW_RD_CS_SETUP;
         t.cs_pulse  = `SMWS_SLOW_RD_CS_PULSE;
         t.cycle     = `SMWS_SLOW_RD_CYCLE;
      end else if (slow) begin
         t.stb_setup = `SMWS_SLOW_WR_STB_SETUP;
         t.stb_pulse = `SMWS_SLOW_WR_STB_PULSE;
         t.cs_setup  = `SMWS_SLOW_WR_CS_SETUP;
         t.cs_pulse  = `SMWS_SLOW_WR_CS_PULSE;
         t.cycle     = `SMWS_SLOW_WR_CYCLE;
      end else if (!w) begin
         t.stb_setup = c.read_strobe_setup_len;
         t.stb_pulse = c.read_strobe_pulse_len;
         t.cs_setup  = c.cs_read_setup_len;
         t.cs_pulse  = c.cs_read_pulse_len;
         t.cycle     = c.read_cycle_len;
      end else begin
         t.stb_setup = c.write_strobe_setup_len;
         t.stb_pulse = c.write_strobe_pulse_len;
         t.cs_setup  = c.cs_write_setup_len;
         t.cs_pulse  = c.cs_write_pulse_len;
         t.cycle     = c.write_cycle_len;
      end
      // Controlling strobe is the data strobe or the chip select
      t.ctl_setup = by_stb ? t.stb_setup : t.cs_setup;
      t.ctl_pulse = by_stb ? t.stb_pulse : t.cs_pulse;
      return t;
   endfunction : timing

   // May the next access start, given the float period still running
   function automatic logic float_ok(input smws_st_s s,
                                     input logic w,
                                     input logic [`SMWS_CS_W-1:0] cs,
                                     input logic [7:0] setup);
      logic need;
      need = s.flt_pend && (w || (cs != s.flt_cs));
      if (!need) begin
         return 1'b1;
      end
      if (s.flt_cnt == `SMWS_FLT_ZERO) begin
         return 1'b1;
      end
      // Residue hidden under the setup of the next access
      return s.flt_opt && ({4'h0, s.flt_cnt} <= setup);
   endfunction : float_ok

   // ****************************************
   // Next-state logic
   // ****************************************

   // Wait qualification for the access in progress
   always_comb begin
      wait_on  = !st_reg.wait_s2;
      in_ctl   = phase(st_reg.cnt, st_reg.tim.ctl_setup,
                       st_reg.tim.ctl_pulse);
      last_ctl = st_reg.cnt == ctl_last(st_reg.tim);
      hold     = 1'b0;
      if (st_reg.state == SMWS_ACCESS && wait_on) begin
         case (st_reg.wait_mode)
            `SMWS_WAIT_FROZEN: begin
               hold = in_ctl;
            end
            `SMWS_WAIT_READY: begin
               hold = in_ctl && last_ctl;
            end
            default: begin
               hold = 1'b0;
            end
         endcase
      end
   end

   // Sequencer, float tracking and strobe generation
   always_comb begin
      st_next = st_reg;
      st_next.done = 1'b0;
      st_next.hold = hold;
      // Second stage reads only the first stage
      st_next.wait_s1 = ext_wait_n_in;
      st_next.wait_s2 = st_reg.wait_s1;
      // Float period keeps running between accesses too
      if (st_reg.flt_cnt != `SMWS_FLT_ZERO) begin
         st_next.flt_cnt = st_reg.flt_cnt - `SMWS_FLT_ONE;
      end
      case (st_reg.state)
         SMWS_IDLE: begin
            if (req_valid_in) begin
               // Waveform latched once, so a mode change mid-access
               // cannot alter the access already under way
               st_next.tim = timing(req_in.cfg, req_in.is_write,
                                    slow_clock_in);
               st_next.is_write  = req_in.is_write;
               st_next.cs        = req_in.cs;
               st_next.slow_cur  = slow_clock_in;
               st_next.float_len = req_in.cfg.float_cycles;
               st_next.float_opt = req_in.cfg.float_opt;
               // Wait is meaningless under the fixed slow waveform
               st_next.wait_mode = slow_clock_in ? `SMWS_WAIT_OFF
                                   : req_in.cfg.ext_wait_mode;
               st_next.ready = 1'b0;
               if (slow_clock_in != st_reg.slow_used) begin
                  st_next.state = SMWS_RELOAD;
               end else if (float_ok(st_reg, req_in.is_write,
                                     req_in.cs,
                                     st_next.tim.ctl_setup)) begin
                  st_next.state    = SMWS_ACCESS;
                  st_next.cnt      = `SMWS_CNT_ZERO;
                  st_next.flt_pend = 1'b0;
               end else begin
                  st_next.state = SMWS_GATE;
               end
            end
         end
         SMWS_RELOAD: begin
            // One cycle to take up the new waveform set
            st_next.slow_used = st_reg.slow_cur;
            st_next.state     = SMWS_GATE;
         end
         SMWS_GATE: begin
            if (float_ok(st_reg, st_reg.is_write, st_reg.cs,
                         st_reg.tim.ctl_setup)) begin
               st_next.state    = SMWS_ACCESS;
               st_next.cnt      = `SMWS_CNT_ZERO;
               st_next.flt_pend = 1'b0;
            end
         end
         SMWS_ACCESS: begin
            // A held counter keeps every strobe where it is
            if (!hold) begin
               if (!st_reg.is_write && last_ctl) begin
                  // Controlling strobe rises now, so hold cycles
                  // of the read already eat into the float time
                  st_next.flt_cnt  = st_reg.float_len;
                  st_next.flt_pend = 1'b1;
                  st_next.flt_opt  = st_reg.float_opt;
                  st_next.flt_cs   = st_reg.cs;
               end
               if (st_reg.cnt == {1'b0, st_reg.tim.cycle} -
                                 `SMWS_ONE10) begin
                  st_next.state = SMWS_IDLE;
                  st_next.ready = 1'b1;
                  st_next.done  = 1'b1;
               end else begin
                  st_next.cnt = st_reg.cnt + `SMWS_ONE10;
               end
            end
         end
         default: begin
            st_next.state = SMWS_IDLE;
            st_next.ready = 1'b1;
         end
      endcase
      // Strobes from the next counter so that they leave a flop
      st_next.rd_n = `SMWS_STROBE_OFF;
      st_next.wr_n = `SMWS_STROBE_OFF;
      st_next.cs_n = `SMWS_CS_OFF;
      if (st_next.state == SMWS_ACCESS) begin
         if (phase(st_next.cnt, st_next.tim.stb_setup,
                   st_next.tim.stb_pulse)) begin
            if (st_next.is_write) begin
               st_next.wr_n = !`SMWS_STROBE_OFF;
            end else begin
               st_next.rd_n = !`SMWS_STROBE_OFF;
            end
         end
         if (phase(st_next.cnt, st_next.tim.cs_setup,
                   st_next.tim.cs_pulse)) begin
            st_next.cs_n[st_next.cs] = !`SMWS_STROBE_OFF;
         end
      end
   end

   // ****************************************
   // State register
   // ****************************************

   // Synchronous reset; wait stages come up released
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         st_reg         <= '0;
         st_reg.state   <= SMWS_IDLE;
         st_reg.wait_s1 <= `SMWS_WAIT_RELEASED;
         st_reg.wait_s2 <= `SMWS_WAIT_RELEASED;
         st_reg.rd_n    <= `SMWS_STROBE_OFF;
         st_reg.wr_n    <= `SMWS_STROBE_OFF;
         st_reg.cs_n    <= `SMWS_CS_OFF;
         st_reg.ready   <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   // Outputs straight from the state register
   assign req_ready_out      = st_reg.ready;
   assign done_out           = st_reg.done;
   assign wait_hold_out      = st_reg.hold;
   assign read_strobe_n_out  = st_reg.rd_n;
   assign write_strobe_n_out = st_reg.wr_n;
   assign chip_select_n_out  = st_reg.cs_n;

endmodule : smws_ctrl

// >>> testbench/smws_mem_model.sv
// Memory model that answers the controller with its wait line.
// Assumes lat_in and len_in stay steady while chip select is low.
`timescale 1ns/1ps
module smws_mem_model (
   input  wire logic       clk_in,
   input  wire logic       cs_n_in,
   input  wire logic [7:0] lat_in,
   input  wire logic [7:0] len_in,
   output logic            ext_wait_n_out
);
   // ****************************************
   // Wait answer
   // ****************************************
   logic [7:0] age_reg;

   // Age of the access, counted from chip select falling
   always @(posedge clk_in) begin
      if (cs_n_in !== 1'b0) begin
         age_reg <= 8'h00;
      end else begin
         age_reg <= age_reg + 8'h01;
      end
   end

   // Wait is a response to a request, so deselect releases it to the
   // pulled-up level; len_in of zero never asserts it
   assign ext_wait_n_out = ((cs_n_in === 1'b0) && (age_reg >= lat_in)
      && (age_reg < lat_in + len_in)) ? 1'b0 : 1'b1;
endmodule : smws_mem_model

// >>> testbench/smws_ctrl_props.sv
// Concurrent checks on the ports of the wait-state controller.
// Assumes binding into smws_ctrl; sees its ports only.
`timescale 1ns/1ps
`include "smws_params.svh"
module smws_ctrl_props (
   input wire logic                    clk_in,
   input wire logic                    rst_n_in,
   input wire logic                    req_valid_in,
   input wire smws_pkg::smws_req_s     req_in,
   input wire logic                    slow_clock_in,
   input wire logic                    ext_wait_n_in,
   input wire logic                    req_ready_out,
   input wire logic                    done_out,
   input wire logic                    wait_hold_out,
   input wire logic                    read_strobe_n_out,
   input wire logic                    write_strobe_n_out,
   input wire logic [`SMWS_NUM_CS-1:0] chip_select_n_out
);
   import smws_pkg::*;
   // ****************************************
   // Helper state
   // ****************************************
   logic slow_q;
   logic wr_q;
   logic off_q;
   logic ctl_q;
   logic idle_q;
   wire  idle_w  = &chip_select_n_out;
   wire  start_w = idle_q && !idle_w;

   // Attributes of the access in flight, latched at acceptance
   always_ff @(posedge clk_in) begin
      idle_q <= idle_w;
      if (req_valid_in && req_ready_out) begin
         slow_q <= slow_clock_in;
         wr_q   <= req_in.is_write;
         off_q  <= req_in.cfg.ext_wait_mode == `SMWS_WAIT_OFF;
         ctl_q  <= req_in.is_write ? req_in.cfg.write_mode
                                   : req_in.cfg.read_mode;
      end
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   // Reset itself is checked, so this one is never disabled
   a_reset_idle: assert property (disable iff (1'b0) !rst_n_in |=>
      read_strobe_n_out && write_strobe_n_out && idle_w && req_ready_out
      && !done_out) else $error("outputs not idle after reset");
   a_slow_read: assert property (
      start_w && slow_q && !wr_q |-> read_strobe_n_out
      ##1 (!read_strobe_n_out && !idle_w)
      ##1 (read_strobe_n_out && idle_w && done_out))
      else $error("slow read waveform wrong");
   a_slow_write: assert property (
      start_w && slow_q && wr_q |-> write_strobe_n_out
      ##1 (!write_strobe_n_out && !idle_w)
      ##1 (write_strobe_n_out && !idle_w) ##1 (idle_w && done_out))
      else $error("slow write waveform wrong");
   a_wait_off: assert property (
      off_q || slow_q |-> !wait_hold_out)
      else $error("wait honoured while disabled");
   a_hold_frozen: assert property (
      wait_hold_out |-> $stable(read_strobe_n_out) && !done_out
      && $stable(write_strobe_n_out) && $stable(chip_select_n_out))
      else $error("outputs moved in a held cycle");
   a_hold_pulse: assert property (
      wait_hold_out && ctl_q |-> !read_strobe_n_out || !write_strobe_n_out)
      else $error("hold outside controlling pulse");
   a_sync_delay: assert property (
      $rose(wait_hold_out) |-> !$past(ext_wait_n_in, 3)
      || !$past(ext_wait_n_in, 4))
      else $error("wait took effect without two flops");
   a_done_idle: assert property (done_out |-> req_ready_out && idle_w
      && read_strobe_n_out && write_strobe_n_out ##1 !done_out)
      else $error("done pulse not idle or too long");
endmodule : smws_ctrl_props

bind smws_ctrl smws_ctrl_props smws_ctrl_props_i (
   .clk_in(clk_in), .rst_n_in(rst_n_in), .req_valid_in(req_valid_in),
   .req_in(req_in), .slow_clock_in(slow_clock_in),
   .ext_wait_n_in(ext_wait_n_in), .req_ready_out(req_ready_out),
   .done_out(done_out), .wait_hold_out(wait_hold_out),
   .read_strobe_n_out(read_strobe_n_out),
   .write_strobe_n_out(write_strobe_n_out),
   .chip_select_n_out(chip_select_n_out));

// >>> testbench/smws_ctrl_tb.sv
// Bench for the wait-state controller: scripted accesses with checks.
// Assumes smws_mem_model answers on the wait line.
`timescale 1ns/1ps
`include "smws_params.svh"
module smws_ctrl_tb;
   import smws_pkg::*;
   // ****************************************
   // Harness
   // ****************************************
   logic                    clk_in = 1'b0;
   logic                    rst_n_in = 1'b0;
   logic                    req_valid_in = 1'b0;
   smws_req_s               req_in = '0;
   logic                    slow_clock_in = 1'b0;
   logic                    ext_wait_n;
   logic                    req_ready_out;
   logic                    done_out;
   logic                    wait_hold_out;
   logic                    rd_n;
   logic                    wr_n;
   logic [`SMWS_NUM_CS-1:0] cs_n;
   logic [7:0]              lat_c = 8'h00;
   logic [7:0]              len_c = 8'h00;
   int bad_count = 0;
   int check_count = 0;
   int since = 0;
   int lat, n_rd, n_wr, n_cs, holds, gap;
   logic [1:0] wm [6] = '{2'h2, 2'h3, 2'h3, 2'h0, 2'h2, 2'h3};
   logic [7:0] wl [6] = '{8'h01, 8'h00, 8'h06, 8'h01, 8'h06, 8'h01};
   logic [7:0] wn [6] = '{8'h03, 8'h02, 8'h03, 8'h03, 8'h02, 8'h08};
   int         eh [6] = '{3, 0, 0, 0, 0, -1};

   always #5 clk_in = ~clk_in;

   smws_ctrl smws_ctrl_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .req_valid_in(req_valid_in), .req_in(req_in),
      .slow_clock_in(slow_clock_in), .ext_wait_n_in(ext_wait_n),
      .req_ready_out(req_ready_out), .done_out(done_out),
      .wait_hold_out(wait_hold_out), .read_strobe_n_out(rd_n),
      .write_strobe_n_out(wr_n), .chip_select_n_out(cs_n));
   smws_mem_model smws_mem_model_i (.clk_in(clk_in), .cs_n_in(&cs_n),
      .lat_in(lat_c), .len_in(len_c), .ext_wait_n_out(ext_wait_n));

   task automatic check(input string what, input logic [15:0] seen,
                        input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %s expected %0d seen %0d", what, exp, seen);
      end
   endtask : check

   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : conclude

   // One access with equal read and write timing; counts what it sees
   task automatic access(input logic w, input logic [1:0] cs,
      input logic [7:0] s, input logic [7:0] p, input logic [7:0] h,
      input logic [3:0] f, input logic o, input logic [1:0] m,
      input logic drop);
      logic [8:0] c;
      c = {1'b0, s} + {1'b0, p} + {1'b0, h};
      since++;
      @(negedge clk_in);
      req_in = '0;
      req_in.is_write = w;
      req_in.cs = cs;
      req_in.cfg.read_strobe_setup_len = s;
      req_in.cfg.write_strobe_setup_len = s;
      req_in.cfg.read_strobe_pulse_len = p;
      req_in.cfg.write_strobe_pulse_len = p;
      req_in.cfg.cs_read_pulse_len = c[7:0];
      req_in.cfg.cs_write_pulse_len = c[7:0];
      req_in.cfg.read_cycle_len = c;
      req_in.cfg.write_cycle_len = c;
      req_in.cfg.read_mode = 1'b1;
      req_in.cfg.write_mode = 1'b1;
      req_in.cfg.float_cycles = f;
      req_in.cfg.float_opt = o;
      req_in.cfg.ext_wait_mode = m;
      req_valid_in = 1'b1;
      lat = 0;
      while (req_ready_out !== 1'b1 && lat < 100) begin
         @(negedge clk_in);
         lat++;
      end
      @(posedge clk_in);
      @(negedge clk_in);
      req_valid_in = 1'b0;
      if (drop) begin
         slow_clock_in = 1'b0;
      end
      lat = 1;
      {n_rd, n_wr, n_cs, holds, gap} = {32'd0, 32'd0, 32'd0, 32'd0, -32'd1};
      forever begin
         n_rd += (rd_n === 1'b0);
         n_wr += (wr_n === 1'b0);
         n_cs += ((&cs_n) === 1'b0);
         holds += (wait_hold_out === 1'b1);
         if (rd_n === 1'b0 || wr_n === 1'b0) begin
            if (gap < 0) begin
               gap = since;
            end
            since = 0;
         end else begin
            since++;
         end
         if (done_out === 1'b1 || lat > 250) begin
            break;
         end
         @(negedge clk_in);
         lat++;
      end
   endtask : access

   // Watchdog sized well above the few hundred cycles the tests need
   initial begin
      #50000;
      bad_count++;
      conclude();
   end

   initial begin
      repeat (8) @(posedge clk_in);
      @(negedge clk_in);
      rst_n_in = 1'b1;
      // Float gaps measured from strobe rise to the next strobe fall
      access(0, 0, 1, 2, 1, 4'h6, 0, 0, 0);
      access(1, 0, 3, 2, 1, 4'h0, 0, 0, 0);
      check("gap read write", gap >= 9, 1);
      access(0, 1, 1, 2, 1, 4'hf, 0, 0, 0);
      access(0, 2, 3, 2, 1, 4'h0, 0, 0, 0);
      check("gap read read", gap >= 18, 1);
      access(0, 1, 1, 2, 1, 4'h6, 0, 0, 0);
      access(1, 2, 3, 2, 1, 4'h0, 0, 0, 0);
      check("gap other cs", gap >= 9, 1);
      access(0, 0, 1, 2, 1, 4'h9, 1, 0, 0);
      access(1, 0, 3, 2, 1, 4'h0, 0, 0, 0);
      check("gap optimised", gap >= 9 && gap <= 11, 1);
      access(0, 0, 1, 2, 4, 4'h3, 0, 0, 0);
      access(1, 0, 1, 2, 1, 4'h0, 0, 0, 0);
      check("gap in hold", gap <= 8, 1);
      $display("test float done");
      // Hold of one cycle and pulse of five cycles
      for (int i = 0; i < 6; i++) begin
         lat_c = wl[i];
         len_c = wn[i];
         access(1, 3, 1, 5, 1, 4'h0, 0, wm[i], 0);
         if (eh[i] < 0) begin
            check("ready held", holds != 0, 1);
         end else begin
            check("holds", holds, eh[i]);
         end
         check("wait length", lat, 8 + holds);
      end
      len_c = 8'h00;
      $display("test wait done");
      // Programmed timing is odd on purpose; wait stays off here
      slow_clock_in = 1'b1;
      access(1, 1, 4, 4, 1, 4'h0, 0, 0, 0);
      check("slow wr length", lat, 6);
      check("slow wr pulse", n_wr, 1);
      check("slow wr cs", n_cs, 3);
      access(0, 1, 4, 4, 1, 4'h0, 0, 0, 1);
      check("slow rd length", lat, 3);
      check("slow rd pulse", n_rd, 1);
      check("slow rd cs", n_cs, 2);
      access(1, 1, 1, 2, 1, 4'h0, 0, 0, 0);
      check("normal again", lat, 7);
      $display("test slow done");
      conclude();
   end
endmodule : smws_ctrl_tb
